// File: include/fplb_pkg.sv
// Constants and types shared by the front-panel LED blinker
`default_nettype none
package fplb_pkg;
	localparam int          ADDR_W      = 8;
	localparam int          DATA_W      = 8;
	localparam int          PHASE_W     = 6;
	localparam int          LEVEL_W     = 8;

	// Register offsets
	localparam logic [7:0]  DEEP_OFF    = 8'hf4;
	localparam logic [7:0]  GREEN_OFF   = 8'hf5;
	localparam logic [7:0]  YELLOW_OFF  = 8'hf6;
	localparam logic [7:0]  STATUS_OFF  = 8'hf8;
	localparam logic [7:0]  SELECT_OFF  = 8'hf9;

	// Values after reset
	localparam logic [7:0]  DEEP_RST    = 8'h00;
	localparam logic [7:0]  GREEN_RST   = 8'h87;
	localparam logic [7:0]  YELLOW_RST  = 8'h47;
	localparam logic [7:0]  SELECT_RST  = 8'h00;

	// Field positions
	localparam int          AUTO_BIT    = 7;
	localparam int          CLR_BIT     = 6;
	localparam int          POL_BIT     = 5;
	localparam int          CODE_LSB    = 0;
	localparam int          DEEP_Y_LSB  = 4;
	localparam int          DEEP_G_LSB  = 0;
	localparam int          SEL_Y_BIT   = 5;
	localparam int          SEL_G_BIT   = 4;
	localparam logic [7:0]  GREEN_MASK  = 8'hef;
	localparam logic [7:0]  YELLOW_MASK = 8'h6f;
	localparam logic [7:0]  SELECT_MASK = 8'h30;

	// Pattern codes
	localparam logic [3:0]  CODE_OFF    = 4'h0;
	localparam logic [3:0]  CODE_LOW    = 4'h7;
	localparam logic [2:0]  CODE_FAST   = 3'h6;

	// Timing
	localparam int          CLK_HZ        = 100_000_000;
	localparam int          BLINK_TICK_MS = 250;
	localparam int          BLINK_TICK_CYC = CLK_HZ / 1000 * BLINK_TICK_MS;
	localparam int          FADE_STEP_US  = 3906;
	localparam int          FADE_STEP_CYC = CLK_HZ / 1_000_000 * FADE_STEP_US;
	localparam int          PWM_DIV_CYC   = 16;

	typedef logic [3:0] fplb_code_t;

	typedef enum logic [1:0] {
		PWR_RUN,
		PWR_S3,
		PWR_S5
	} fplb_power_e;
endpackage : fplb_pkg
`default_nettype wire

// File: include/fplb_pat_if.sv
// Pattern request and pin answer between the top and one pattern generator
`default_nettype none
interface fplb_pat_if;
	logic [fplb_pkg::PHASE_W-1:0] phase;
	logic                         fade_on;
	fplb_pkg::fplb_code_t         code;
	logic                         polarity;
	logic                         drive_low;

	modport gen (
		input  phase,
		input  fade_on,
		input  code,
		input  polarity,
		output drive_low
	);
	modport top (
		output phase,
		output fade_on,
		output code,
		output polarity,
		input  drive_low
	);
endinterface : fplb_pat_if
`default_nettype wire

// File: hdl/fplb_pattern_gen.sv
// Decodes one pattern code into an open-drain pull-down request
`default_nettype none
module fplb_pattern_gen (
	fplb_pat_if.gen pat
);
	import fplb_pkg::*;

	logic       active;
	logic [2:0] sel;

	always_comb begin
		active         = 1'b0;
		sel            = 3'(CODE_FAST - pat.code[2:0]);
		pat.drive_low  = 1'b0;
		if (pat.code[3]) begin
			active        = pat.fade_on;
			pat.drive_low = pat.polarity ? ~active : active;
		end else if (pat.code == CODE_LOW) begin
			pat.drive_low = 1'b1;
		end else if (pat.code == CODE_OFF) begin
			pat.drive_low = 1'b0;
		end else begin
			// Code 6 takes the fastest phase bit, code 1 the slowest
			active        = pat.phase[sel];
			pat.drive_low = pat.polarity ? ~active : active;
		end
	end
endmodule : fplb_pattern_gen
`default_nettype wire

// File: hdl/fplb_top.sv
// Front-panel green and yellow LED blinker with its register file
// Notes on behaviour
// - Deep register bits 7-4 give yellow code in deepest sleep when select bit 5 is 0.
// - Deep register bits 3-0 give green code in deepest sleep when select bit 4 is 0.
// - Code with top bit set fades the LED whatever the lower bits.
// - Code 0111 pulls the pin low all the time.
// - Code 0110 blinks at 2 Hz, half on half off.
// - Code 0101 blinks at 1 Hz, code 0100 at 0.5 Hz, even duty.
// - Codes 0011, 0010, 0001 blink at 0.25, 0.125, 0.0625 Hz, even duty.
// - Code 0000 leaves the open-drain pin released.
// - Auto bit clear: LEDs follow only clear-on-sleep bits and their codes.
// - Auto bit set, its reset value: LEDs follow sleep pins and codes.
// - Green clear bit 0: green code zeroed while sleep3 and power-good product low.
// - Green clear bit 1: green code kept while that product is low.
// - Green polarity bit 0 means active low, 1 active high.
// - Deep register clears to 00h only on the battery reset.
// - Green control resets to 87h on standby reset only.
// - Yellow polarity bit 0 means active low, 1 active high.
// - Yellow clear bit 0 zeroes yellow code while asleep, else code is kept.
//
// Design decision made here: the strobed register port.
`default_nettype none
module fplb_top #(
	parameter int unsigned BLINK_TICK_CYC = fplb_pkg::BLINK_TICK_CYC,
	parameter int unsigned FADE_STEP_CYC  = fplb_pkg::FADE_STEP_CYC,
	parameter int unsigned PWM_DIV_CYC    = fplb_pkg::PWM_DIV_CYC
) (
	input  wire logic                          ref_clk_in,
	input  wire logic                          reset_n_in,
	input  wire logic                          battery_reset_n_in,
	input  wire logic [fplb_pkg::ADDR_W-1:0]   reg_addr_in,
	input  wire logic [fplb_pkg::DATA_W-1:0]   reg_wdata_in,
	input  wire logic                          reg_write_in,
	input  wire logic                          reg_read_in,
	output logic      [fplb_pkg::DATA_W-1:0]   reg_rdata_out,
	input  wire logic                          sleep_state5_n_in,
	input  wire logic                          sleep_state3_n_in,
	input  wire logic                          power_good_in,
	input  wire logic                          green_indicator_pin_in,
	output logic                               green_indicator_pin_out,
	output logic                               green_indicator_pin_oe_n_out,
	input  wire logic                          yellow_indicator_pin_in,
	output logic                               yellow_indicator_pin_out,
	output logic                               yellow_indicator_pin_oe_n_out
);
	import fplb_pkg::*;

	localparam int BLINK_W = $clog2(BLINK_TICK_CYC);
	localparam int FADE_W  = $clog2(FADE_STEP_CYC);
	localparam int PWM_W   = (PWM_DIV_CYC > 1) ? $clog2(PWM_DIV_CYC) : 1;

	localparam logic [BLINK_W-1:0] BLINK_LAST = BLINK_W'(BLINK_TICK_CYC - 1);
	localparam logic [FADE_W-1:0]  FADE_LAST  = FADE_W'(FADE_STEP_CYC - 1);
	localparam logic [PWM_W-1:0]   PWM_LAST   = PWM_W'(PWM_DIV_CYC - 1);
	localparam logic [LEVEL_W-1:0] LEVEL_TOP  = '1;

	typedef struct packed {
		logic [DATA_W-1:0]  green;
		logic [DATA_W-1:0]  yellow;
		logic [DATA_W-1:0]  select;
		logic [DATA_W-1:0]  rdata;
		logic [1:0]         s3_sync;
		logic [1:0]         s5_sync;
		logic [1:0]         pg_sync;
		logic [1:0]         gpin_sync;
		logic [1:0]         ypin_sync;
		logic [BLINK_W-1:0] blink_div;
		logic [PHASE_W-1:0] phase;
		logic [FADE_W-1:0]  fade_div;
		logic [PWM_W-1:0]   pwm_div;
		logic [LEVEL_W-1:0] pwm_cnt;
		logic [LEVEL_W-1:0] duty;
		logic               fade_up;
		logic               g_oe_n;
		logic               y_oe_n;
	} fplb_state_s;

	fplb_state_s       s_q;
	fplb_state_s       s_d;
	logic [DATA_W-1:0] deep_q;
	logic [DATA_W-1:0] deep_d;
	logic [1:0]        rst_sync_q;
	logic [1:0]        bat_sync_q;
	logic              rst_n;
	logic              bat_rst_n;
	logic              awake;
	fplb_power_e       power;
	fplb_code_t        green_eff;
	fplb_code_t        yellow_eff;

	fplb_pat_if g_if ();
	fplb_pat_if y_if ();

	// Reset release is synchronised; assertion stays asynchronous
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	always_ff @(posedge ref_clk_in or negedge battery_reset_n_in) begin
		if (!battery_reset_n_in) begin
			bat_sync_q <= 2'h0;
		end else begin
			bat_sync_q <= {bat_sync_q[0], 1'b1};
		end
	end

	assign rst_n     = rst_sync_q[1];
	assign bat_rst_n = bat_sync_q[1];

	// Sleep state decoded from synchronised pins
	assign awake = s_q.s3_sync[1] & s_q.pg_sync[1];

	always_comb begin
		if (awake) begin
			power = PWR_RUN;
		end else if (!s_q.s5_sync[1]) begin
			power = PWR_S5;
		end else begin
			power = PWR_S3;
		end
	end

	// Deep codes only replace the main ones in automatic mode in the deepest state
	always_comb begin
		green_eff  = s_q.green[CODE_LSB +: 4];
		yellow_eff = s_q.yellow[CODE_LSB +: 4];
		if (s_q.green[AUTO_BIT] && power == PWR_S5) begin
			if (!s_q.select[SEL_G_BIT]) begin
				green_eff = deep_q[DEEP_G_LSB +: 4];
			end
			if (!s_q.select[SEL_Y_BIT]) begin
				yellow_eff = deep_q[DEEP_Y_LSB +: 4];
			end
		end
	end

	assign g_if.phase    = s_q.phase;
	assign g_if.fade_on  = s_q.pwm_cnt < s_q.duty;
	assign g_if.code     = green_eff;
	assign g_if.polarity = s_q.green[POL_BIT];
	assign y_if.phase    = s_q.phase;
	assign y_if.fade_on  = s_q.pwm_cnt < s_q.duty;
	assign y_if.code     = yellow_eff;
	assign y_if.polarity = s_q.yellow[POL_BIT];

	fplb_pattern_gen u_green (
		.pat (g_if.gen)
	);

	fplb_pattern_gen u_yellow (
		.pat (y_if.gen)
	);

	// Deep register lives on the battery reset so standby loss keeps it
	always_comb begin
		deep_d = deep_q;
		if (reg_write_in && reg_addr_in == DEEP_OFF) begin
			deep_d = reg_wdata_in;
		end
	end

	always_ff @(posedge ref_clk_in or negedge bat_rst_n) begin
		if (!bat_rst_n) begin
			deep_q <= DEEP_RST;
		end else begin
			deep_q <= deep_d;
		end
	end

	always_comb begin
		s_d = s_q;

		// Input synchronisers
		s_d.s3_sync   = {s_q.s3_sync[0], sleep_state3_n_in};
		s_d.s5_sync   = {s_q.s5_sync[0], sleep_state5_n_in};
		s_d.pg_sync   = {s_q.pg_sync[0], power_good_in};
		s_d.gpin_sync = {s_q.gpin_sync[0], green_indicator_pin_in};
		s_d.ypin_sync = {s_q.ypin_sync[0], yellow_indicator_pin_in};

		// One divider feeds a binary counter, so each bit is half the rate of the one below
		if (s_q.blink_div == BLINK_LAST) begin
			s_d.blink_div = '0;
			s_d.phase     = s_q.phase + PHASE_W'(1);
		end else begin
			s_d.blink_div = s_q.blink_div + BLINK_W'(1);
		end

		// PWM carrier well above flicker rate
		if (s_q.pwm_div == PWM_LAST) begin
			s_d.pwm_div = '0;
			s_d.pwm_cnt = s_q.pwm_cnt + LEVEL_W'(1);
		end else begin
			s_d.pwm_div = s_q.pwm_div + PWM_W'(1);
		end

		// Triangle ramp of the duty level
		if (s_q.fade_div == FADE_LAST) begin
			s_d.fade_div = '0;
			if (s_q.fade_up) begin
				if (s_q.duty == LEVEL_TOP) begin
					s_d.fade_up = 1'b0;
				end else begin
					s_d.duty = s_q.duty + LEVEL_W'(1);
				end
			end else begin
				if (s_q.duty == '0) begin
					s_d.fade_up = 1'b1;
				end else begin
					s_d.duty = s_q.duty - LEVEL_W'(1);
				end
			end
		end else begin
			s_d.fade_div = s_q.fade_div + FADE_W'(1);
		end

		// Register writes; reserved bits stay zero
		if (reg_write_in) begin
			unique case (reg_addr_in)
				GREEN_OFF: begin
					s_d.green = reg_wdata_in & GREEN_MASK;
				end
				YELLOW_OFF: begin
					s_d.yellow = reg_wdata_in & YELLOW_MASK;
				end
				SELECT_OFF: begin
					s_d.select = reg_wdata_in & SELECT_MASK;
				end
				default: begin
				end
			endcase
		end

		// Sleep clearing overrides a write in the same cycle, as the pin level holds anyway
		if (!awake && !s_q.green[CLR_BIT]) begin
			s_d.green[CODE_LSB +: 4] = CODE_OFF;
		end
		if (!awake && !s_q.yellow[CLR_BIT]) begin
			s_d.yellow[CODE_LSB +: 4] = CODE_OFF;
		end
		// With the clear bits set the codes are simply left as they are

		// Read data stands only in the cycle after the strobe
		s_d.rdata = '0;
		if (reg_read_in) begin
			unique case (reg_addr_in)
				DEEP_OFF: begin
					s_d.rdata = deep_q;
				end
				GREEN_OFF: begin
					s_d.rdata = s_q.green;
				end
				YELLOW_OFF: begin
					s_d.rdata = s_q.yellow;
				end
				SELECT_OFF: begin
					s_d.rdata = s_q.select;
				end
				STATUS_OFF: begin
					s_d.rdata = {2'h0, s_q.fade_up, s_q.pg_sync[1],
						s_q.s5_sync[1], s_q.s3_sync[1],
						s_q.ypin_sync[1], s_q.gpin_sync[1]};
				end
				default: begin
					s_d.rdata = '0;
				end
			endcase
		end

		// Pins registered so the outputs never glitch
		s_d.g_oe_n = ~g_if.drive_low;
		s_d.y_oe_n = ~y_if.drive_low;
	end

	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			s_q           <= '0;
			s_q.green     <= GREEN_RST;
			s_q.yellow    <= YELLOW_RST;
			s_q.select    <= SELECT_RST;
			// Pins start at their awake and released levels, so reset codes are not cleared
			s_q.s3_sync   <= 2'h3;
			s_q.s5_sync   <= 2'h3;
			s_q.pg_sync   <= 2'h3;
			s_q.gpin_sync <= 2'h3;
			s_q.ypin_sync <= 2'h3;
			s_q.fade_up   <= 1'b1;
			s_q.g_oe_n    <= 1'b1;
			s_q.y_oe_n    <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Open drain: the pad only ever pulls low
	assign green_indicator_pin_out       = 1'b0;
	assign yellow_indicator_pin_out      = 1'b0;
	assign green_indicator_pin_oe_n_out  = s_q.g_oe_n;
	assign yellow_indicator_pin_oe_n_out = s_q.y_oe_n;
	assign reg_rdata_out                 = s_q.rdata;
endmodule : fplb_top
`default_nettype wire

// File: verif/fplb_assertions.sv
// Port-level checks for the front-panel LED blinker
`default_nettype none
module fplb_assertions (
	input wire logic       ref_clk_in,
	input wire logic       reset_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic       reg_write_in,
	input wire logic       reg_read_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic       sleep_state5_n_in,
	input wire logic       sleep_state3_n_in,
	input wire logic       green_indicator_pin_oe_n_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in);
	logic gclr_q;
	logic wr_g;
	logic asleep;
	assign wr_g = reg_write_in && reg_addr_in == 8'hf5;
	// Bus-side shadow of the green clear bit, so sleep checks need no internal probe
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			gclr_q <= 1'b0;
		end else if (wr_g) begin
			gclr_q <= reg_wdata_in[6];
		end
	end
	assign asleep = !sleep_state3_n_in && sleep_state5_n_in && !gclr_q && !reg_write_in;
	property p_rd_stand;
		!$past(reg_read_in) |-> reg_rdata_out == 8'h00;
	endproperty
	a_rd_stand: assert property (p_rd_stand) else $error("stray read data");
	property p_unmapped;
		$past(reg_read_in) && !($past(reg_addr_in) inside {8'hf4, 8'hf5, 8'hf6, 8'hf8, 8'hf9})
		|-> reg_rdata_out == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_rsv;
		$past(reg_read_in) && $past(reg_addr_in) inside {8'hf5, 8'hf6} |-> !reg_rdata_out[4];
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bit reads one");
	property p_wr_rd_g;
		$past(reg_read_in) && $past(reg_addr_in) == 8'hf5 && $past(wr_g, 3)
		&& ($past(reg_wdata_in, 3) & 8'h40) != 8'h00
		|-> reg_rdata_out == ($past(reg_wdata_in, 3) & 8'hef);
	endproperty
	a_wr_rd_g: assert property (p_wr_rd_g) else $error("green control readback");
	property p_wr_rd_deep;
		$past(reg_read_in) && $past(reg_addr_in) == 8'hf4 && $past(reg_write_in, 3)
		&& $past(reg_addr_in, 3) == 8'hf4 |-> reg_rdata_out == $past(reg_wdata_in, 3);
	endproperty
	a_wr_rd_deep: assert property (p_wr_rd_deep) else $error("deep readback");
	property p_code0;
		wr_g && (reg_wdata_in & 8'hcf) == 8'h40 ##1 !reg_write_in
		|=> green_indicator_pin_oe_n_out;
	endproperty
	a_code0: assert property (p_code0) else $error("code 0 drives pad");
	property p_code7;
		wr_g && (reg_wdata_in & 8'hdf) == 8'h47 ##1 !reg_write_in
		|=> !green_indicator_pin_oe_n_out;
	endproperty
	a_code7: assert property (p_code7) else $error("code 7 not low");
	property p_sleep_clr;
		asleep [*6] |-> green_indicator_pin_oe_n_out;
	endproperty
	a_sleep_clr: assert property (p_sleep_clr) else $error("green kept in sleep");
	c_code7: cover property (wr_g && reg_wdata_in[3:0] == 4'h7);
	c_asleep: cover property (asleep [*6]);
	c_deep_rd: cover property ($past(reg_read_in) && $past(reg_addr_in) == 8'hf4);
endmodule : fplb_assertions
bind fplb_top fplb_assertions u_chk (.ref_clk_in, .reset_n_in, .reg_addr_in, .reg_wdata_in,
	.reg_write_in, .reg_read_in, .reg_rdata_out, .sleep_state5_n_in, .sleep_state3_n_in,
	.green_indicator_pin_oe_n_out);
`default_nettype wire

// File: verif/fplb_panel_model.sv
// Front panel model: pulled-up LED pads and platform sleep pins
`default_nettype none
module fplb_panel_model (
	input  wire logic g_oe_n_in,
	input  wire logic y_oe_n_in,
	input  wire logic s3_req_in,
	input  wire logic s5_req_in,
	input  wire logic pg_req_in,
	output logic      g_pad_out,
	output logic      y_pad_out,
	output logic      s3_n_out,
	output logic      s5_n_out,
	output logic      pg_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// LED to the supply pulls a released open-drain pad high
	assign g_pad_out = g_oe_n_in ? 1'b1 : 1'b0;
	assign y_pad_out = y_oe_n_in ? 1'b1 : 1'b0;
	assign s3_n_out = s3_req_in;
	assign s5_n_out = s5_req_in;
	assign pg_out = pg_req_in;
endmodule : fplb_panel_model
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench for the front-panel LED blinker
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BT = 8;
	logic       clk, rst_n, bat_n, wr_s, rd_s, s3, s5, pg;
	logic [7:0] addr, wd, rdata;
	logic       s3_n, s5_n, pg_w, goe, yoe, gpad, ypad, gout, yout;
	int         err_count, comparisons, cycles;
	fplb_top #(.BLINK_TICK_CYC(BT), .FADE_STEP_CYC(4), .PWM_DIV_CYC(1)) u_dut (
		.ref_clk_in(clk), .reset_n_in(rst_n), .battery_reset_n_in(bat_n),
		.reg_addr_in(addr), .reg_wdata_in(wd), .reg_write_in(wr_s), .reg_read_in(rd_s),
		.reg_rdata_out(rdata), .sleep_state5_n_in(s5_n), .sleep_state3_n_in(s3_n),
		.power_good_in(pg_w), .green_indicator_pin_in(gpad), .green_indicator_pin_out(gout),
		.green_indicator_pin_oe_n_out(goe), .yellow_indicator_pin_in(ypad),
		.yellow_indicator_pin_out(yout), .yellow_indicator_pin_oe_n_out(yoe));
	fplb_panel_model u_panel (.g_oe_n_in(goe), .y_oe_n_in(yoe), .s3_req_in(s3),
		.s5_req_in(s5), .pg_req_in(pg), .g_pad_out(gpad), .y_pad_out(ypad),
		.s3_n_out(s3_n), .s5_n_out(s5_n), .pg_out(pg_w));
	task automatic summarize;
		$display("mismatches %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : summarize
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %0t %s got %0h exp %0h", $time, m, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		chk(16'(rdata), 16'(e), "read");
	endtask : rchk
	task automatic pads(input logic g, input logic y);
		#1;
		// Open-drain data pins must never drive high
		chk(16'({gpad, ypad, gout, yout}), 16'({g, y, 2'b00}), "pads");
	endtask : pads
	task automatic t_regs;
		rchk(8'hf8, 8'h3c);
		rchk(8'hf4, 8'h00);
		rchk(8'hf5, 8'h87);
		rchk(8'hf6, 8'h47);
		rchk(8'hf7, 8'h00);
		wr(8'hf5, 8'hff);
		rchk(8'hf5, 8'hef);
		wr(8'hf4, 8'ha5);
		rchk(8'hf4, 8'ha5);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_wells;
		@(posedge clk);
		rst_n <= 1'b0;
		cyc(4);
		rst_n <= 1'b1;
		cyc(4);
		rchk(8'hf4, 8'ha5);
		rchk(8'hf5, 8'h87);
		wr(8'hf5, 8'h45);
		@(posedge clk);
		bat_n <= 1'b0;
		cyc(4);
		bat_n <= 1'b1;
		cyc(4);
		rchk(8'hf4, 8'h00);
		rchk(8'hf5, 8'h45);
		$display("t_wells done");
	endtask : t_wells
	task automatic t_blink;
		logic v;
		int   n;
		for (int c = 6; c > 0; c--) begin
			wr(8'hf5, 8'h40 | 8'(c));
			cyc(3);
			#1;
			// First change only aligns; the second interval is a full half period
			for (int k = 0; k < 2; k++) begin
				v = gpad;
				n = 0;
				while (gpad === v && n < 600) begin
					@(posedge clk);
					#1;
					n++;
				end
			end
			chk(16'(n), 16'(BT << (6 - c)), "half period");
		end
		wr(8'hf5, 8'h67);
		cyc(3);
		pads(0, 0);
		wr(8'hf5, 8'h60);
		cyc(3);
		pads(1, 0);
		for (int c = 8; c < 16; c++) begin
			wr(8'hf5, 8'h40 | 8'(c));
			n = 0;
			repeat (1100) begin
				@(posedge clk);
				#1;
				n += int'(!gpad);
			end
			chk(16'(n > 0 && n < 1100), 16'h0001, "fade");
		end
		$display("t_blink done");
	endtask : t_blink
	task automatic t_pol;
		int t;
		wr(8'hf5, 8'h46);
		wr(8'hf6, 8'h66);
		cyc(3);
		t = 0;
		repeat (64) begin
			@(posedge clk);
			#1;
			t += int'(gpad);
			chk(16'(ypad), 16'(!gpad), "polarity");
		end
		// Four whole periods of the fastest blink: released exactly half the time
		chk(16'(t), 16'h0020, "green duty");
		$display("t_pol done");
	endtask : t_pol
	task automatic t_sleep;
		wr(8'hf5, 8'h07);
		wr(8'hf6, 8'h47);
		cyc(3);
		pads(0, 0);
		s3 <= 1'b0;
		cyc(8);
		pads(1, 0);
		rchk(8'hf5, 8'h00);
		s3 <= 1'b1;
		cyc(8);
		pads(1, 0);
		wr(8'hf5, 8'h47);
		pg <= 1'b0;
		cyc(8);
		pads(0, 0);
		rchk(8'hf5, 8'h47);
		wr(8'hf6, 8'h07);
		cyc(3);
		pads(0, 1);
		pg <= 1'b1;
		$display("t_sleep done");
	endtask : t_sleep
	task automatic t_deep;
		wr(8'hf5, 8'hc0);
		wr(8'hf6, 8'h47);
		wr(8'hf4, 8'h07);
		wr(8'hf9, 8'h00);
		s3 <= 1'b0;
		s5 <= 1'b0;
		cyc(8);
		pads(0, 1);
		wr(8'hf9, 8'h10);
		cyc(3);
		pads(1, 1);
		wr(8'hf9, 8'h20);
		cyc(3);
		pads(0, 0);
		s5 <= 1'b1;
		cyc(8);
		pads(1, 0);
		s5 <= 1'b0;
		wr(8'hf9, 8'h00);
		wr(8'hf5, 8'h40);
		cyc(8);
		pads(1, 0);
		s3 <= 1'b1;
		s5 <= 1'b1;
		$display("t_deep done");
	endtask : t_deep
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			err_count++;
			summarize();
		end
	end
	initial begin
		{rst_n, bat_n, wr_s, rd_s, addr, wd} = '0;
		{s3, s5, pg} = 3'b111;
		cyc(10);
		rst_n <= 1'b1;
		bat_n <= 1'b1;
		cyc(4);
		t_regs();
		t_wells();
		t_blink();
		t_pol();
		t_sleep();
		t_deep();
		summarize();
	end
endmodule : tb_top
`default_nettype wire
